/* File: hw/tx_ts_pkg.sv */
`default_nettype none
// ****************************************************************
// Shared constants and carriers of the transmit timeslot control.
// ****************************************************************
package tx_ts_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] SDL_ADDR = 12'h10a;
  localparam logic [11:0] PART_ID_ADDR = 12'h1fe;
  localparam logic [11:0] REV_ADDR = 12'h1ff;
  localparam logic [11:0] TS_BASE = 12'h300;
  localparam logic [11:0] TS_END = 12'h317;
  localparam int TS_NUM = 24;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RD_IDLE = 8'h00;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CSEL_HI = 7;
  localparam int CSEL_LO = 6;
  localparam int ZSEL_HI = 5;
  localparam int ZSEL_LO = 4;
  localparam int DESRC_HI = 3;
  localparam int DESRC_LO = 2;

  // ****************************************************************
  // Field codes.
  // ****************************************************************
  localparam logic [1:0] CSEL_CTL1 = 2'h0;
  localparam logic [1:0] CSEL_CTL2 = 2'h1;
  localparam logic [1:0] CSEL_SDL = 2'h2;
  localparam logic [1:0] CSEL_CTL3 = 2'h3;
  localparam logic [1:0] ZS_NONE = 2'h0;
  localparam logic [1:0] ZS_BIT7 = 2'h1;
  localparam logic [1:0] ZS_ALT = 2'h2;
  localparam logic [1:0] ZS_DDS = 2'h3;

  // Bit 8 is the least significant octet bit, bit 7 the next one up.
  localparam logic [7:0] BIT8_MASK = 8'h01;
  localparam logic [7:0] BIT7_MASK = 8'h02;
  localparam logic [7:0] DDS_CODE = 8'h98;
  localparam logic [7:0] ZERO_OCTET = 8'h00;

  // Owner of an outgoing octet.
  typedef enum logic [1:0] {
    OWN_CTL1 = 2'b00,
    OWN_CTL2 = 2'b01,
    OWN_CTL3 = 2'b10,
    OWN_SDL = 2'b11
  } owner_t;

  // Octet offered by the framer.
  typedef struct packed {
    logic [4:0] slot;
    logic sig_frame;
    logic sig_bit;
    logic datalink;
    logic [7:0] data;
  } in_octet_t;

  // Octet handed on toward the line.
  typedef struct packed {
    logic [4:0] slot;
    owner_t owner;
    logic [1:0] de_src;
    logic datalink;
    logic [7:0] data;
  } out_octet_t;

  // Whole state of the block.
  typedef struct packed {
    logic [TS_NUM-1:0][7:0] ts;
    logic [7:0] sdl;
    logic [7:0] rdata;
    out_octet_t [1:0] buffer;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } state_t;

  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_ONE = 2'h1;

endpackage : tx_ts_pkg

`default_nettype wire

/* File: hw/tx_timeslot_channel_control.sv */
`timescale 1ns/100ps
`default_nettype none

// How it works
// R1: Select field 00/01/11 picks controller 1/2/3.
// R2: Select 10 defers to signaling-select bits 3-2.
// R3: Any controller on slots; datalink only controller 1.
// R4: Twenty-four slot registers at consecutive addresses.
// R5: Suppression field bits 5-4; 00 sends unchanged.
// R6: Suppression 01 stuffs bit 7.
// R7: Suppression 10 stuffs bit 8, or 7 conditionally.
// R8: Suppression 11 replaces octet with 0x98.
// R9: Read-only part identity, writes ignored.
// R10: Read-only silicon revision register.
// R11: Suppression acts only on all-zero octets.
module tx_timeslot_channel_control #(
  parameter logic [7:0] PART_IDENTITY = 8'h5a, // Arbitrary value.
  parameter logic [7:0] SILICON_REVISION = 8'h02 // Arbitrary value.
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic in_valid,
  output logic in_ready,
  input wire tx_ts_pkg::in_octet_t in_octet,
  output logic out_valid,
  input wire logic out_ready,
  output tx_ts_pkg::out_octet_t out_octet
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Tells whether an address falls on a timeslot control register.
  function automatic logic ts_hit(input logic [11:0] addr);
    ts_hit = (addr >= tx_ts_pkg::TS_BASE) && (addr <= tx_ts_pkg::TS_END);
  endfunction : ts_hit

  // Turns a timeslot register address into its slot number.
  function automatic logic [4:0] ts_idx(input logic [11:0] addr);
    logic [11:0] diff;
    diff = addr - tx_ts_pkg::TS_BASE;
    ts_idx = diff[4:0];
  endfunction : ts_idx

  // Applies the chosen zero code suppression to one octet.
  function automatic logic [7:0] suppress(input logic [7:0] data, input logic [1:0] mode,
                                          input logic sig_frame, input logic sig_bit);
    logic [7:0] res;
    res = data;
    if (data == tx_ts_pkg::ZERO_OCTET) // R11
    begin
      case (mode)
        tx_ts_pkg::ZS_NONE: res = data; // R5
        tx_ts_pkg::ZS_BIT7: res = data | tx_ts_pkg::BIT7_MASK; // R6
        tx_ts_pkg::ZS_ALT:
        begin
          if (!sig_frame)
          begin
            res = data | tx_ts_pkg::BIT8_MASK; // R7
          end
          else if (!sig_bit)
          begin
            res = data | tx_ts_pkg::BIT7_MASK; // R7
          end
        end
        tx_ts_pkg::ZS_DDS: res = tx_ts_pkg::DDS_CODE; // R8
        default: res = data;
      endcase
    end
    suppress = res;
  endfunction : suppress

  // ****************************************************************
  // State and handshake terms.
  // ****************************************************************
  tx_ts_pkg::state_t s;
  tx_ts_pkg::state_t next_s;
  logic accept;
  logic pop;
  logic [7:0] slot_cfg;
  tx_ts_pkg::out_octet_t entry;

  // Ready and valid come straight from the buffer fill level.
  assign in_ready = (s.count != tx_ts_pkg::BUF_FULL);
  assign out_valid = (s.count != tx_ts_pkg::BUF_EMPTY);
  assign accept = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_octet = s.buffer[s.rd_ptr];
  assign reg_rdata = s.rdata;

  // ****************************************************************
  // Octet path: owner decode and suppression.
  // ****************************************************************

  // Builds the outgoing entry from the slot's control register.
  always_comb
  begin
    slot_cfg = tx_ts_pkg::REG_RESET;
    if (in_octet.slot < 5'(tx_ts_pkg::TS_NUM))
    begin
      slot_cfg = s.ts[in_octet.slot];
    end
    entry.slot = in_octet.slot;
    entry.datalink = in_octet.datalink;
    entry.de_src = s.sdl[tx_ts_pkg::DESRC_HI:tx_ts_pkg::DESRC_LO];
    entry.data = in_octet.data;
    if (in_octet.datalink)
    begin
      entry.owner = tx_ts_pkg::OWN_CTL1; // R3
    end
    else
    begin
      case (slot_cfg[tx_ts_pkg::CSEL_HI:tx_ts_pkg::CSEL_LO])
        tx_ts_pkg::CSEL_CTL1: entry.owner = tx_ts_pkg::OWN_CTL1; // R1
        tx_ts_pkg::CSEL_CTL2: entry.owner = tx_ts_pkg::OWN_CTL2; // R1
        tx_ts_pkg::CSEL_CTL3: entry.owner = tx_ts_pkg::OWN_CTL3; // R1
        tx_ts_pkg::CSEL_SDL: entry.owner = tx_ts_pkg::OWN_SDL; // R2
        default: entry.owner = tx_ts_pkg::OWN_CTL1;
      endcase
      entry.data = suppress(in_octet.data, slot_cfg[tx_ts_pkg::ZSEL_HI:tx_ts_pkg::ZSEL_LO],
                            in_octet.sig_frame, in_octet.sig_bit);
    end
  end

  // ****************************************************************
  // Next state: registers, read port and two-entry buffer.
  // ****************************************************************

  // Computes the next state of the whole block.
  always_comb
  begin
    next_s = s;
    next_s.rdata = tx_ts_pkg::RD_IDLE;
    if (reg_wr)
    begin
      if (ts_hit(reg_addr))
      begin
        next_s.ts[ts_idx(reg_addr)] = reg_wdata; // R4
      end
      else if (reg_addr == tx_ts_pkg::SDL_ADDR)
      begin
        next_s.sdl = reg_wdata;
      end
    end
    if (reg_rd)
    begin
      if (ts_hit(reg_addr))
      begin
        next_s.rdata = s.ts[ts_idx(reg_addr)]; // R4
      end
      else if (reg_addr == tx_ts_pkg::SDL_ADDR)
      begin
        next_s.rdata = s.sdl;
      end
      else if (reg_addr == tx_ts_pkg::PART_ID_ADDR)
      begin
        next_s.rdata = PART_IDENTITY; // R9
      end
      else if (reg_addr == tx_ts_pkg::REV_ADDR)
      begin
        next_s.rdata = SILICON_REVISION; // R10
      end
    end
    if (accept)
    begin
      next_s.buffer[s.wr_ptr] = entry;
      next_s.wr_ptr = ~s.wr_ptr;
    end
    if (pop)
    begin
      next_s.rd_ptr = ~s.rd_ptr;
    end
    if (accept && !pop)
    begin
      next_s.count = s.count + tx_ts_pkg::BUF_ONE;
    end
    else if (pop && !accept)
    begin
      next_s.count = s.count - tx_ts_pkg::BUF_ONE;
    end
  end

  // Registers the state; reset clears controls and empties the buffer.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************

  // Code 01 hands the slot to controller 2.
  owner_ctl_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R1
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && !in_octet.datalink && in_octet.slot < 5'h18
     && slot_cfg[7:6] == tx_ts_pkg::CSEL_CTL2) |=> out_valid && out_octet.owner == tx_ts_pkg::OWN_CTL2)
    else $error("slot select 01 did not pick controller 2");

  // Code 10 defers to the signaling-select source bits.
  owner_defer_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && !in_octet.datalink && in_octet.slot < 5'h18
     && slot_cfg[7:6] == tx_ts_pkg::CSEL_SDL) |=> out_octet.owner == tx_ts_pkg::OWN_SDL
     && out_octet.de_src == $past(s.sdl[3:2]))
    else $error("deferred slot lost its source select");

  // Datalink octets always belong to controller 1.
  datalink_owner_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R3
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && in_octet.datalink)
    |=> out_octet.owner == tx_ts_pkg::OWN_CTL1 && out_octet.datalink)
    else $error("datalink octet not owned by controller 1");

  // A slot register write reads back at the next read.
  ts_readback_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    (reg_wr && ts_hit(reg_addr)) ##1 (reg_rd && reg_addr == $past(reg_addr))
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("slot register read back wrong");

  // Suppression off leaves a zero octet zero.
  zs_none_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R5
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && !in_octet.datalink && in_octet.slot < 5'h18
     && slot_cfg[5:4] == tx_ts_pkg::ZS_NONE) |=> out_octet.data == $past(in_octet.data))
    else $error("octet changed with suppression off");

  // Bit 7 stuffing on a zero octet.
  zs_bit7_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R6
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && !in_octet.datalink && in_octet.slot < 5'h18
     && slot_cfg[5:4] == tx_ts_pkg::ZS_BIT7 && in_octet.data == 8'h00) |=> out_octet.data == 8'h02)
    else $error("bit 7 stuffing wrong");

  // Alternate scheme stuffs bit 8 outside signaling frames.
  zs_alt_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R7
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && !in_octet.datalink && in_octet.slot < 5'h18
     && slot_cfg[5:4] == tx_ts_pkg::ZS_ALT && in_octet.data == 8'h00)
    |=> out_octet.data == ($past(in_octet.sig_frame) ? ($past(in_octet.sig_bit) ? 8'h00 : 8'h02)
                                                      : 8'h01))
    else $error("alternate stuffing wrong");

  // Data service suppression sends 0x98.
  zs_dds_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R8
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && !in_octet.datalink && in_octet.slot < 5'h18
     && slot_cfg[5:4] == tx_ts_pkg::ZS_DDS && in_octet.data == 8'h00) |=> out_octet.data == 8'h98)
    else $error("data service code wrong");

  // Identity read is constant even after a write to it.
  part_id_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R9
    (reg_rd && reg_addr == tx_ts_pkg::PART_ID_ADDR) |=> reg_rdata == PART_IDENTITY)
    else $error("part identity read wrong");

  // Revision read returns the revision value.
  revision_read_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R10
    (reg_rd && reg_addr == tx_ts_pkg::REV_ADDR) |=> reg_rdata == SILICON_REVISION)
    else $error("revision read wrong");

  // Nonzero octets pass untouched by suppression.
  nonzero_pass_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R11
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && in_octet.data != 8'h00)
    |=> out_octet.data == $past(in_octet.data))
    else $error("nonzero octet altered");

  // The buffer never overfills and holds while stalled.
  buffer_hold_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (out_valid && !out_ready) |=> out_valid && $stable(out_octet) && s.count <= 2'h2)
    else $error("stalled output changed");

  // Code 00 hands the slot to controller 1.
  owner_ctl1_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R1
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && !in_octet.datalink && in_octet.slot < 5'h18
     && slot_cfg[7:6] == tx_ts_pkg::CSEL_CTL1) |=> out_octet.owner == tx_ts_pkg::OWN_CTL1)
    else $error("slot select 00 did not pick controller 1");

  // Code 11 hands the slot to controller 3.
  owner_ctl3_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R1
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && !in_octet.datalink && in_octet.slot < 5'h18
     && slot_cfg[7:6] == tx_ts_pkg::CSEL_CTL3) |=> out_octet.owner == tx_ts_pkg::OWN_CTL3)
    else $error("slot select 11 did not pick controller 3");

  // A signaling select write reads back at the next read.
  sdl_readback_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    (reg_wr && reg_addr == tx_ts_pkg::SDL_ADDR) ##1 (reg_rd && reg_addr == tx_ts_pkg::SDL_ADDR)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("signaling select read back wrong");

  // Every octet carries its slot number and the current source select.
  octet_tags_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    (accept && s.count == tx_ts_pkg::BUF_EMPTY) |=> out_octet.slot == $past(in_octet.slot)
     && out_octet.de_src == $past(s.sdl[3:2]))
    else $error("octet tags wrong");

  // Datalink octets bypass suppression.
  datalink_plain_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R3
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && in_octet.datalink)
    |=> out_octet.data == $past(in_octet.data))
    else $error("datalink octet altered");

  // Slot numbers past the last register use controller 1 and no suppression.
  slot_range_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    (accept && s.count == tx_ts_pkg::BUF_EMPTY && !in_octet.datalink && in_octet.slot >= 5'h18)
    |=> out_octet.owner == tx_ts_pkg::OWN_CTL1 && out_octet.data == $past(in_octet.data))
    else $error("slot beyond the map not passed plain");

  // Reads outside the map return the idle value.
  unmapped_read_a : assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    (reg_rd && !ts_hit(reg_addr) && reg_addr != tx_ts_pkg::SDL_ADDR
     && reg_addr != tx_ts_pkg::PART_ID_ADDR && reg_addr != tx_ts_pkg::REV_ADDR)
    |=> reg_rdata == tx_ts_pkg::RD_IDLE)
    else $error("unmapped read returned data");

  // Read data fall back to the idle value when no read was taken.
  rdata_idle_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == tx_ts_pkg::RD_IDLE)
    else $error("read data stood too long");

  // Two octets taken without a pop fill the buffer.
  fill_refuse_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (accept && !pop && s.count == tx_ts_pkg::BUF_ONE) |=> !in_ready && out_valid)
    else $error("full buffer still takes octets");

  // Popping the only entry without a new one empties the buffer.
  drain_empty_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (pop && !accept && s.count == tx_ts_pkg::BUF_ONE) |=> !out_valid && in_ready)
    else $error("empty buffer still offers an octet");

  // An octet taken while the only entry leaves comes out next.
  pass_through_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (accept && pop && s.count == tx_ts_pkg::BUF_ONE) |=> out_valid
     && out_octet.slot == $past(in_octet.slot))
    else $error("buffer order broken");

  // The fill level never passes two entries.
  fill_bound_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    s.count <= tx_ts_pkg::BUF_FULL)
    else $error("buffer fill level out of range");

endmodule : tx_timeslot_channel_control

`default_nettype wire

/* File: verif/octet_sink.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Downstream consumer of the octet stream.
// ****************************************************************
module octet_sink #(
  parameter int SEED = 20109
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] mode,
  output var logic out_ready = 1'b0
);
  int seed = SEED;

  // Ready is redrawn each cycle: mode 0 takes most octets, mode 1 stalls most, mode 2 stalls all.
  always @(posedge core_clk)
  begin
    if (sys_rst || mode == 2'h2)
      out_ready <= 1'b0;
    else if (mode == 2'h1)
      out_ready <= ($random(seed) % 4) == 0;
    else
      out_ready <= ($random(seed) % 4) != 0;
  end
endmodule : octet_sink
`default_nettype wire

/* File: verif/test_tx_timeslot_channel_control.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Self-checking bench of the transmit timeslot control.
// ****************************************************************
module test_tx_timeslot_channel_control;
  localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary value.
  localparam logic [7:0] REV_VAL = 8'h07; // Arbitrary value.
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic in_valid = 1'b0;
  logic in_ready;
  tx_ts_pkg::in_octet_t in_octet = '0;
  logic out_valid;
  logic out_ready;
  tx_ts_pkg::out_octet_t out_octet;
  logic [1:0] mode = 2'h0;
  logic [7:0] ts_m [24];
  logic [7:0] sdl_m = 8'h00;
  tx_ts_pkg::out_octet_t exp_q [$];
  int seed = 20109;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] rd_exp = 8'h00;
  logic [7:0] rd_mask = 8'h00;
  logic [7:0] seen_exp = 8'h00;
  logic [7:0] seen_mask = 8'h00;
  logic rd_seen = 1'b0;

  tx_timeslot_channel_control #(
    .PART_IDENTITY(ID_VAL),
    .SILICON_REVISION(REV_VAL)
  ) u_tx_timeslot_channel_control (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_ready(in_ready), .in_octet(in_octet), .out_valid(out_valid),
    .out_ready(out_ready), .out_octet(out_octet)
  );

  octet_sink u_octet_sink (
    .core_clk(core_clk), .sys_rst(sys_rst), .mode(mode), .out_ready(out_ready)
  );

  // Free-running 25 MHz clock.
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  // Counts a comparison and reports a mismatch.
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // One-cycle register write; the strobes stay as set until the next call or bus_idle.
  task wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  // One-cycle register read; the scoreboard checks the data in the following cycle.
  task rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    rd_exp <= e;
    rd_mask <= m;
    @(posedge core_clk);
  endtask : rd

  // Drops both strobes at the edge that took the last request.
  task bus_idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : bus_idle

  // Offers one octet and holds it until an edge with ready high takes it.
  task send(input tx_ts_pkg::in_octet_t o);
    logic r;
    in_valid <= 1'b1;
    in_octet <= o;
    do
    begin
      @(negedge core_clk);
      r = in_ready;
      @(posedge core_clk);
    end while (!r);
  endtask : send

  // Random octet, half of them all zero, a few beyond the last slot.
  function automatic tx_ts_pkg::in_octet_t rnd();
    tx_ts_pkg::in_octet_t o;
    o.slot = 5'($unsigned($random(seed)) % 26);
    o.sig_frame = 1'($random(seed));
    o.sig_bit = 1'($random(seed));
    o.datalink = ($random(seed) % 8) == 0;
    o.data = ($random(seed) % 2 == 0) ? 8'h00 : 8'($random(seed));
    return o;
  endfunction : rnd

  // Expected output octet from the slot settings held by the bench.
  function automatic tx_ts_pkg::out_octet_t expf(input tx_ts_pkg::in_octet_t i);
    logic [7:0] c;
    tx_ts_pkg::out_octet_t e;
    c = (i.slot < 5'd24) ? ts_m[i.slot] : 8'h00;
    e.slot = i.slot;
    e.de_src = sdl_m[3:2];
    e.datalink = i.datalink;
    e.data = i.data;
    case (c[7:6])
      2'h0: e.owner = tx_ts_pkg::OWN_CTL1;
      2'h1: e.owner = tx_ts_pkg::OWN_CTL2;
      2'h2: e.owner = tx_ts_pkg::OWN_SDL;
      default: e.owner = tx_ts_pkg::OWN_CTL3;
    endcase
    if (i.datalink)
      e.owner = tx_ts_pkg::OWN_CTL1;
    if (!i.datalink && i.data == 8'h00)
    begin
      case (c[5:4])
        2'h1: e.data = 8'h02;
        2'h2: e.data = !i.sig_frame ? 8'h01 : (i.sig_bit ? 8'h00 : 8'h02);
        2'h3: e.data = 8'h98;
        default: e.data = 8'h00;
      endcase
    end
    return e;
  endfunction : expf

  // Prints the counts and the verdict, then ends the run.
  task print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Scoreboard of the stream, in order, plus the hang limit.
  always @(posedge core_clk)
  begin
    cycles++;
    rd_seen <= reg_rd && !sys_rst;
    seen_exp <= rd_exp;
    seen_mask <= rd_mask;
    if (rd_seen)
      chk(reg_rdata & seen_mask, seen_exp & seen_mask, "register read");
    else if (!sys_rst)
      chk(reg_rdata, tx_ts_pkg::RD_IDLE, "read data outside a read");
    if (!sys_rst && out_valid && out_ready)
    begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0, "octet with no cause");
      else
        chk(out_octet, exp_q.pop_front(), "octet");
    end
    if (!sys_rst && in_valid && in_ready)
      exp_q.push_back(expf(in_octet));
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  // Main sequence: identity, map edges, then four rounds of settings and traffic.
  initial
  begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(tx_ts_pkg::TS_BASE + 12'h005, 8'h00, 8'hff);
    rd(tx_ts_pkg::PART_ID_ADDR, ID_VAL, 8'hff);
    wr(tx_ts_pkg::PART_ID_ADDR, ~ID_VAL);
    rd(tx_ts_pkg::PART_ID_ADDR, ID_VAL, 8'hff);
    wr(tx_ts_pkg::REV_ADDR, ~REV_VAL);
    rd(tx_ts_pkg::REV_ADDR, REV_VAL, 8'hff);
    rd(tx_ts_pkg::TS_END + 12'h001, 8'h00, 8'hff);
    for (int round = 0; round < 4; round++)
    begin
      mode <= (round == 1) ? 2'h2 : 2'(round % 2);
      for (int s = 0; s < 24; s++)
      begin
        ts_m[s] = (round == 0 && s < 16) ? {4'(s), 4'h0} : 8'($random(seed));
        wr(tx_ts_pkg::TS_BASE + 12'(s), ts_m[s]);
      end
      rd(tx_ts_pkg::TS_END, ts_m[23], 8'hff);
      sdl_m = 8'($random(seed));
      wr(tx_ts_pkg::SDL_ADDR, sdl_m);
      rd(tx_ts_pkg::SDL_ADDR, sdl_m, 8'h0c);
      for (int s = 0; s < 24; s++)
        rd(tx_ts_pkg::TS_BASE + 12'(s), ts_m[s], 8'hff);
      bus_idle();
      if (round == 1)
      begin
        send(rnd());
        send(rnd());
        in_valid <= 1'b0;
        @(negedge core_clk);
        chk(in_ready, 1'b0, "full buffer still ready");
        @(posedge core_clk);
        mode <= 2'h1;
      end
      for (int n = 0; n < 150; n++)
      begin
        send(rnd());
        if ($random(seed) % 4 == 0)
        begin
          in_valid <= 1'b0;
          @(posedge core_clk);
        end
      end
      in_valid <= 1'b0;
      for (int w = 0; w < 1000 && exp_q.size() != 0; w++)
        @(posedge core_clk);
      chk(exp_q.size(), 0, "octets lost");
    end
    print_verdict();
  end
endmodule : test_tx_timeslot_channel_control
`default_nettype wire
